// ### verif/hdlc_overhead_receive_path_tb.sv
// Self-checking bench for the HDLC receive path
`timescale 1ns/10ps
`include "hdorx_map.vh"
module hdlc_overhead_receive_path_tb;
    // ----------------------------------------
    // Bench signals, bus tasks and scenarios
    // ----------------------------------------
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        clk_en_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    wire  [31:0] prdata_o;
    wire         pready_o;
    wire         pslverr_o;
    wire         line_bit;
    wire         line_stb;
    logic [31:0] rdv;
    logic [31:0] last;
    logic        perr;
    logic        rev = 1'b0;
    logic [31:0] exp_q[$];
    int          err_total = 0;
    int          n_tests = 0;
    int          c;
    hdorx_top #(.DEPTH_LOG2(8)) dut (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .clk_en_i   (clk_en_i),
        .line_bit_i (line_bit),
        .line_stb_i (line_stb),
        .psel_i     (psel_i),
        .penable_i  (penable_i),
        .pwrite_i   (pwrite_i),
        .paddr_i    (paddr_i),
        .pwdata_i   (pwdata_i),
        .prdata_o   (prdata_o),
        .pready_o   (pready_o),
        .pslverr_o  (pslverr_o)
    );
    hdorx_line_model fm (
        .ref_clk_i  (ref_clk_i),
        .line_bit_o (line_bit),
        .line_stb_o (line_stb)
    );
    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 40);
        if (pready_o !== 1'b1) begin
            err_total++;
            $display("unexpected pready: no answer");
            finish_test();
        end
        rdv = prdata_o;
        perr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdv);
    endtask
    task automatic drain(input int n);
        repeat (n) rdc(`HDORX_DATA_OFS, exp_q.pop_front(), "fifo word");
    endtask
    // Reads until the invalid word; keeps the last valid one
    task automatic count_out(output int n);
        n = 0;
        apb(1'b0, `HDORX_DATA_OFS, 32'h0);
        while (rdv[15] === 1'b1 && n < 300) begin
            last = rdv;
            n++;
            apb(1'b0, `HDORX_DATA_OFS, 32'h0);
        end
        if (n == 300) begin
            err_total++;
            $display("unexpected fifo drain: no invalid word after 300 reads");
            finish_test();
        end
    endtask
    function automatic logic [15:0] crc_byte(input logic [15:0] s, input logic [7:0] v);
        for (int i = 0; i < 8; i++) s = (s >> 1) ^ ((s[0] ^ v[i]) ? 16'h8408 : 16'h0000);
        return s;
    endfunction
    // Sends one packet and its closing flag; raw leaves the last byte unstuffed
    task automatic frame(input logic [7:0] d[$], input logic fcs, input logic bad,
                         input logic raw);
        logic [15:0] crc;
        logic [7:0]  v;
        logic        lst;
        crc = 16'hFFFF;
        foreach (d[i]) begin
            lst = (i == d.size() - 1);
            if (raw && lst) fm.put_raw(d[i], 8);
            else fm.put_data(d[i], 8);
            crc = crc_byte(crc, d[i]);
            if (rev) v = {<<{d[i]}};
            else v = d[i];
            exp_q.push_back({16'h0, 1'b1, 3'h0, bad && lst, 1'b0, lst, i == 0, v});
        end
        if (fcs) begin
            crc = ~crc ^ {15'h0, bad};
            fm.put_data(crc[7:0], 8);
            fm.put_data(crc[15:8], 8);
        end
        fm.put_flag();
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rdc(`HDORX_CTRL_OFS, 32'h0102, "control reset");
        rdc(`HDORX_STAT_OFS, 32'h1, "status reset");
        rdc(`HDORX_STICKY_OFS, 32'h0, "sticky reset");
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, perr});
        chk("unmapped data", 32'h0, rdv);
        rdc(`HDORX_DATA_OFS, 32'h0, "empty read");
        rdc(`HDORX_STICKY_OFS, 32'h2, "empty-read flag");
        apb(1'b1, `HDORX_STICKY_OFS, 32'h2);
        rdc(`HDORX_STICKY_OFS, 32'h0, "sticky clear");
        rdc(`HDORX_STAT_OFS, 32'h1, "status after empty read");
        fm.put_raw(8'hFF, 8);
        fm.put_raw(8'hFF, 5);
        fm.put_flag();
        frame('{8'hFF, 8'h7E, 8'h3C}, 1'b1, 1'b0, 1'b0);
        frame('{8'h81, 8'hF8, 8'h5A}, 1'b1, 1'b1, 1'b0);
        fm.put_raw(8'h3F, 7);
        fm.put_flag();
        frame('{8'hC3, 8'h1F, 8'h66}, 1'b1, 1'b0, 1'b0);
        fm.put_flag();
        fm.put_flag();
        rdc(`HDORX_STAT_OFS, 32'h904, "status level");
        drain(9);
        apb(1'b1, `HDORX_CTRL_OFS, 32'h0103);
        fm.inv = 1'b1;
        fm.put_flag();
        frame('{8'h12, 8'h34, 8'h56}, 1'b1, 1'b0, 1'b0);
        fm.inv = 1'b0;
        drain(3);
        apb(1'b1, `HDORX_CTRL_OFS, 32'h0104);
        rev = 1'b1;
        fm.put_flag();
        frame('{8'h01, 8'h80, 8'hC3, 8'hE7, 8'hA5}, 1'b0, 1'b0, 1'b0);
        rev = 1'b0;
        drain(5);
        apb(1'b1, `HDORX_CTRL_OFS, 32'h0100);
        fm.put_flag();
        frame('{8'hA5, 8'hF8}, 1'b0, 1'b0, 1'b1);
        frame('{8'h5A, 8'hF8}, 1'b0, 1'b0, 1'b0);
        drain(4);
        fm.put_raw(8'hA5, 8);
        fm.put_flag();
        rdc(`HDORX_STAT_OFS, 32'h1, "short gap dropped");
        fm.put_data(8'h11, 8);
        fm.put_data(8'h22, 8);
        fm.put_data(8'h33, 8);
        fm.put_raw(8'hFF, 7);
        fm.put_data(8'h99, 8);
        fm.put_flag();
        count_out(c);
        chk("abort marks", 32'h8600, last & 32'h8600);
        chk("abort discards", 32'h0, {31'h0, c > 3});
        fm.put_data(8'h44, 8);
        fm.put_data(8'h55, 8);
        fm.put_data(8'h06, 3);
        fm.put_flag();
        count_out(c);
        chk("partial marks", 32'h9600, last & 32'h9600);
        apb(1'b1, `HDORX_CTRL_OFS, 32'h8000);
        fm.put_flag();
        for (int i = 0; i < 260; i++) fm.put_data(i[7:0], 8);
        fm.put_flag();
        frame('{8'h77, 8'h88}, 1'b0, 1'b0, 1'b0);
        rdc(`HDORX_STAT_OFS, 32'h10006, "status full");
        // Each drain to the invalid word also latched the empty-read flag
        rdc(`HDORX_STICKY_OFS, 32'h3, "overflow flag");
        repeat (10) apb(1'b0, `HDORX_DATA_OFS, 32'h0);
        frame('{8'h77, 8'h88}, 1'b0, 1'b0, 1'b0);
        count_out(c);
        chk("words after overflow", 32'd246, c);
        chk("overflow abort", 32'h8400, last & 32'h8400);
        exp_q.delete();
        frame('{8'h5A, 8'hA5, 8'h0F}, 1'b0, 1'b0, 1'b0);
        drain(3);
        apb(1'b1, `HDORX_STICKY_OFS, 32'h3);
        rdc(`HDORX_STICKY_OFS, 32'h0, "overflow clear");
        finish_test();
    end
endmodule

// ### verif/hdorx_checker.sv
// Concurrent checks on the register port of the HDLC receive path
`timescale 1ns/10ps
`include "hdorx_map.vh"
module hdorx_checker #(
    parameter DEPTH_LOG2 = 8
) (
    input wire        ref_clk_i,
    input wire        rst_i,
    input wire        clk_en_i,
    input wire        line_bit_i,
    input wire        line_stb_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [7:0]  paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o
);
    // ----------------------------------------
    // Helper state and properties
    // ----------------------------------------
    wire        setup    = psel_i && !penable_i && clk_en_i;
    wire        acc      = psel_i && penable_i && clk_en_i;
    wire        unmapped = paddr_i[7:4] != 4'h0 || paddr_i[1:0] != 2'h0;
    wire        rd_ctrl  = setup && !pwrite_i && paddr_i == `HDORX_CTRL_OFS;
    wire        rd_stat  = setup && !pwrite_i && paddr_i == `HDORX_STAT_OFS;
    wire        rd_stk   = setup && !pwrite_i && paddr_i == `HDORX_STICKY_OFS;
    wire [8:0]  full_lvl = 9'h1 << DEPTH_LOG2;
    logic [15:0] ctrl_reg;
    logic        urd_reg;
    // Shadow of the FF07 control bits software last wrote, so read-back is tied to the write
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `HDORX_CTRL_RST;
            urd_reg  <= 1'b0;
        end else begin
            if (acc && pwrite_i && paddr_i == `HDORX_CTRL_OFS) begin
                ctrl_reg <= pwdata_i[15:0] & 16'hFF07;
            end
            if (acc && !pwrite_i && paddr_i == `HDORX_DATA_OFS && !prdata_o[15]) begin
                urd_reg <= 1'b1;
            end else if (acc && pwrite_i && paddr_i == `HDORX_STICKY_OFS && pwdata_i[1]) begin
                urd_reg <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_ready;
        pready_o == (psel_i && penable_i && clk_en_i);
    endproperty
    a_ready: assert property (p_ready) else $error("pready not equal to access phase");
    property p_hold;
        !setup |=> $stable(prdata_o) && $stable(pslverr_o);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved outside setup");
    property p_err;
        setup |=> pslverr_o == $past(unmapped);
    endproperty
    a_err: assert property (p_err) else $error("slave error does not match address");
    property p_unmap;
        setup && unmapped |=> prdata_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_ctrl;
        rd_ctrl |=> prdata_o == {16'h0, $past(ctrl_reg)};
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control read-back wrong");
    property p_stat;
        rd_stat |=> prdata_o[0] == (prdata_o[16:8] == 9'h0) && prdata_o[16:8] <= full_lvl
            && prdata_o[1] == (prdata_o[16:8] == full_lvl);
    endproperty
    a_stat: assert property (p_stat) else $error("empty or full flag wrong");
    property p_avail;
        rd_stat |=> prdata_o[2] == (prdata_o[16:8] >= {1'b0, $past(ctrl_reg[15:8])});
    endproperty
    a_avail: assert property (p_avail) else $error("data available flag wrong");
    property p_urd;
        rd_stk |=> prdata_o[1] == $past(urd_reg);
    endproperty
    a_urd: assert property (p_urd) else $error("empty-read flag wrong");
    c_full: cover property (rd_stat ##1 prdata_o[1]);
    c_urd: cover property (acc && !pwrite_i && paddr_i == `HDORX_DATA_OFS && !prdata_o[15]);
    c_err: cover property (setup && unmapped);
endmodule
bind hdorx_top hdorx_checker #(.DEPTH_LOG2(DEPTH_LOG2)) u_chk (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .clk_en_i   (clk_en_i),
    .line_bit_i (line_bit_i),
    .line_stb_i (line_stb_i),
    .psel_i     (psel_i),
    .penable_i  (penable_i),
    .pwrite_i   (pwrite_i),
    .paddr_i    (paddr_i),
    .pwdata_i   (pwdata_i),
    .prdata_o   (prdata_o),
    .pready_o   (pready_o),
    .pslverr_o  (pslverr_o)
);

// ### verif/hdorx_line_model.sv
// Line framer model: serial overhead bits paced by a strobe
`timescale 1ns/10ps
`include "hdorx_map.vh"
module hdorx_line_model (
    input  wire  ref_clk_i,
    output logic line_bit_o,
    output logic line_stb_o
);
    // ----------------------------------------
    // Bit pacing, four clocks a bit
    // ----------------------------------------
    logic inv = 1'b0;
    int   ones = 0;
    initial begin
        line_bit_o = 1'b1;
        line_stb_o = 1'b0;
    end
    // Bit valid only while strobe is high; the inverse after, so stale bits show
    task automatic put_bit(input logic b);
        @(posedge ref_clk_i);
        line_bit_o <= b ^ inv;
        line_stb_o <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        line_bit_o <= ~(b ^ inv);
        line_stb_o <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic put_data(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            put_bit(v[i]);
            ones = v[i] ? ones + 1 : 0;
            if (ones == 5) begin
                put_bit(1'b0);
                ones = 0;
            end
        end
    endtask
    task automatic put_raw(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) put_bit(v[i]);
        ones = 0;
    endtask
    task automatic put_flag();
        put_raw(`HDORX_FLAG, 8);
    endtask
endmodule

// ### verilog/hdorx_map.vh
// Register offsets, field positions, reset values and constants of the HDLC receive path
`ifndef HDORX_MAP_VH
`define HDORX_MAP_VH
`define HDORX_CTRL_OFS     8'h00
`define HDORX_STAT_OFS     8'h04
`define HDORX_STICKY_OFS   8'h08
`define HDORX_DATA_OFS     8'h0C
`define HDORX_CTRL_INV     0
`define HDORX_CTRL_FCS     1
`define HDORX_CTRL_REV     2
`define HDORX_CTRL_THR_LSB 8
`define HDORX_CTRL_RST     16'h0102
`define HDORX_STAT_EMPTY   0
`define HDORX_STAT_FULL    1
`define HDORX_STAT_AVAIL   2
`define HDORX_STAT_LVL_LSB 8
`define HDORX_STK_OVF      0
`define HDORX_STK_URD      1
`define HDORX_E_SOP        8
`define HDORX_E_EOP        9
`define HDORX_E_ABT        10
`define HDORX_E_FCS        11
`define HDORX_E_INV        12
`define HDORX_DATA_VALID   15
`define HDORX_FLAG         8'h7E
`define HDORX_CRC_INIT     16'hFFFF
`define HDORX_CRC_POLY     16'h8408
`define HDORX_CRC_GOOD     16'hF0B8
`define HDORX_STUFF_ONES   3'h5
`define HDORX_ABORT_ONES   3'h7
`define HDORX_BYTE_BITS    4'h8
`define HDORX_FCS_HOLD     2'h3
`define HDORX_PLAIN_HOLD   2'h1
`define HDORX_MIN_FREE     16
`endif

// ### verilog/hdorx_top.v
// HDLC overhead receive path: delineation, destuffing, FCS check and receive FIFO
`timescale 1ns/10ps
`include "hdorx_map.vh"

module hdorx_top #(
    parameter DEPTH_LOG2 = 8
) (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire        clk_en_i,
    input  wire        line_bit_i,
    input  wire        line_stb_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o
);

    localparam PW = DEPTH_LOG2 + 1;
    localparam [PW-1:0] DEPTH_P  = {1'b1, {DEPTH_LOG2{1'b0}}};
    localparam integer  MIN_FREE_I = `HDORX_MIN_FREE;
    localparam [PW-1:0] MIN_FREE = MIN_FREE_I[PW-1:0];
    localparam [1:0] ST_HUNT = 2'd0;
    localparam [1:0] ST_PKT  = 2'd1;
    localparam [1:0] ST_DISC = 2'd2;
    localparam [1:0] PD_NONE = 2'd0;
    localparam [1:0] PD_END  = 2'd1;
    localparam [1:0] PD_ABT  = 2'd2;
    localparam [1:0] PD_CLR  = 2'd3;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function [15:0] crc_step;
        input [15:0] c;
        input        d;
        begin
            crc_step = (c >> 1) ^ ((c[0] ^ d) ? `HDORX_CRC_POLY : 16'h0000);
        end
    endfunction

    function [7:0] rev8;
        input [7:0] v;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                rev8[i] = v[7-i];
            end
        end
    endfunction

    function [PW-1:0] g2b;
        input [PW-1:0] g;
        integer i;
        begin
            g2b[PW-1] = g[PW-1];
            for (i = PW - 2; i >= 0; i = i - 1) begin
                g2b[i] = g2b[i+1] ^ g[i];
            end
        end
    endfunction

    function [PW-1:0] b2g;
        input [PW-1:0] b;
        begin
            b2g = b ^ (b >> 1);
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg  [2:0]  vld_sync_reg;
    reg  [1:0]  dat_sync_reg;
    reg  [7:0]  win_reg;
    reg  [3:0]  vcnt_reg;
    reg  [2:0]  raw_ones_reg;
    reg  [2:0]  dat_ones_reg;
    reg  [1:0]  st_reg;
    reg  [1:0]  pend_reg;
    reg  [15:0] crc_reg;
    reg  [7:0]  asm_reg;
    reg  [2:0]  bpos_reg;
    reg  [1:0]  hcnt_reg;
    reg  [7:0]  h0_reg;
    reg  [7:0]  h1_reg;
    reg  [7:0]  h2_reg;
    reg         emit_reg;
    reg  [15:0] ctrl_reg;
    reg  [1:0]  sticky_reg;
    reg         disc_reg;
    reg  [PW-1:0] wr_gray_reg;
    reg  [PW-1:0] rd_gray_reg;
    reg  [31:0] prdata_reg;
    reg         pslverr_reg;
    reg         rd_ok_reg;
    reg  [12:0] mem [0:(1<<DEPTH_LOG2)-1];
    reg         wr_req;
    reg  [12:0] wr_ent;
    reg  [31:0] rd_word;
    reg         rd_err;
    reg  [7:0]  oldest;

    // ------------------------------------------------------------
    // Line input and bit-level detection
    // ------------------------------------------------------------
    // Strobe edge is taken from the settled stages only
    wire       bit_stb  = vld_sync_reg[1] & ~vld_sync_reg[2];
    wire       rx_bit   = dat_sync_reg[1] ^ ctrl_reg[`HDORX_CTRL_INV];
    wire [7:0] win_new  = {win_reg[6:0], rx_bit};
    wire       flag_hit = bit_stb & (win_new == `HDORX_FLAG);
    wire       raw_abt  = bit_stb & rx_bit & (st_reg == ST_PKT)
                          & (raw_ones_reg == `HDORX_ABORT_ONES - 3'h1);
    // Data bits lag the window by eight, so flag bits never reach the packer
    wire       out_bit  = win_reg[7];
    wire       data_ok  = bit_stb & (vcnt_reg == `HDORX_BYTE_BITS) & (st_reg == ST_PKT);
    wire       stuffed  = (dat_ones_reg == `HDORX_STUFF_ONES) & ~out_bit;
    wire       take     = data_ok & ~stuffed;
    wire       byte_done = take & (bpos_reg == 3'd7);
    wire [7:0] asm_new  = {out_bit, asm_reg[7:1]};
    wire [7:0] byte_ord = ctrl_reg[`HDORX_CTRL_REV] ? rev8(asm_new) : asm_new;
    wire       fcs_on   = ctrl_reg[`HDORX_CTRL_FCS];
    // FCS bytes are held back so that the markers land on the last data byte
    wire [1:0] hold_lim = fcs_on ? `HDORX_FCS_HOLD : `HDORX_PLAIN_HOLD;
    wire       short_pkt = ~emit_reg & (hcnt_reg < 2'd2);
    wire       crc_bad  = (crc_reg != `HDORX_CRC_GOOD);

    // ------------------------------------------------------------
    // FIFO status
    // ------------------------------------------------------------
    wire [PW-1:0] wr_bin  = g2b(wr_gray_reg);
    wire [PW-1:0] rd_bin  = g2b(rd_gray_reg);
    wire [PW-1:0] level   = wr_bin - rd_bin;
    wire [PW-1:0] free    = DEPTH_P - level;
    wire          empty   = (level == {PW{1'b0}});
    wire          full    = (level == DEPTH_P);
    wire [PW-1:0] thr     = {{(PW-8){1'b0}}, ctrl_reg[`HDORX_CTRL_THR_LSB+7:`HDORX_CTRL_THR_LSB]};
    wire          avail   = (level >= thr);
    wire [DEPTH_LOG2-1:0] wr_addr = wr_bin[DEPTH_LOG2-1:0];
    wire [DEPTH_LOG2-1:0] prv_addr = wr_addr - {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
    wire [DEPTH_LOG2-1:0] rd_addr = rd_bin[DEPTH_LOG2-1:0];
    wire          is_sop  = wr_ent[`HDORX_E_SOP];
    wire          do_wr   = wr_req & ~full
                            & (~disc_reg | (is_sop & (free >= MIN_FREE)));
    wire          ovf_set = wr_req & full & ~disc_reg;
    wire          do_mark = ovf_set & ~is_sop;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire apb_setup = psel_i & ~penable_i;
    wire apb_done  = psel_i & penable_i & clk_en_i;
    wire wr_ctrl   = apb_done & pwrite_i & (paddr_i == `HDORX_CTRL_OFS);
    wire wr_stky   = apb_done & pwrite_i & (paddr_i == `HDORX_STICKY_OFS);
    wire rd_data   = apb_done & ~pwrite_i & (paddr_i == `HDORX_DATA_OFS);
    wire pop       = rd_data & rd_ok_reg;
    wire urd_set   = rd_data & ~rd_ok_reg;
    wire [1:0] stk_clr = wr_stky ? pwdata_i[1:0] : 2'b00;
    wire [1:0] stk_set = {urd_set, ovf_set};
    // Set beats clear so no event is lost in the clearing cycle
    wire [1:0] sticky_next = (sticky_reg & ~stk_clr) | stk_set;

    assign pready_o  = psel_i & penable_i & clk_en_i;
    assign prdata_o  = prdata_reg;
    assign pslverr_o = pslverr_reg;

    // ------------------------------------------------------------
    // FIFO write request from the packet processor
    // ------------------------------------------------------------
    always @* begin
        wr_req = 1'b0;
        wr_ent = 13'h0000;
        case (hcnt_reg)
            2'd3:    oldest = h2_reg;
            2'd2:    oldest = h1_reg;
            default: oldest = h0_reg;
        endcase
        if (pend_reg == PD_END) begin
            if (!short_pkt) begin
                if (bpos_reg != 3'd0) begin
                    wr_req = 1'b1;
                    wr_ent = {1'b1, 1'b0, 1'b1, 1'b1, ~emit_reg, oldest};
                end else if (fcs_on) begin
                    wr_req = (hcnt_reg >= `HDORX_FCS_HOLD);
                    wr_ent = {1'b0, crc_bad, 1'b0, 1'b1, ~emit_reg, oldest};
                end else begin
                    wr_req = 1'b1;
                    wr_ent = {4'h1, ~emit_reg, oldest};
                end
            end
        end else if (pend_reg == PD_ABT) begin
            wr_req = (hcnt_reg != 2'd0);
            wr_ent = {3'b001, 1'b1, ~emit_reg, oldest};
        end else if (byte_done && hcnt_reg >= hold_lim) begin
            wr_req = 1'b1;
            wr_ent = {4'h0, ~emit_reg, oldest};
        end
    end

    // ------------------------------------------------------------
    // Receive packet processor
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            vld_sync_reg <= 3'b000;
            dat_sync_reg <= 2'b00;
            win_reg      <= 8'h00;
            vcnt_reg     <= 4'h0;
            raw_ones_reg <= 3'h0;
            dat_ones_reg <= 3'h0;
            st_reg       <= ST_HUNT;
            pend_reg     <= PD_NONE;
            crc_reg      <= `HDORX_CRC_INIT;
            asm_reg      <= 8'h00;
            bpos_reg     <= 3'h0;
            hcnt_reg     <= 2'h0;
            h0_reg       <= 8'h00;
            h1_reg       <= 8'h00;
            h2_reg       <= 8'h00;
            emit_reg     <= 1'b0;
        end else if (clk_en_i) begin
            vld_sync_reg <= {vld_sync_reg[1:0], line_stb_i};
            dat_sync_reg <= {dat_sync_reg[0], line_bit_i};
            // A pending end is settled in the cycle after the flag bit
            if (pend_reg != PD_NONE) begin
                pend_reg     <= PD_NONE;
                crc_reg      <= `HDORX_CRC_INIT;
                bpos_reg     <= 3'h0;
                hcnt_reg     <= 2'h0;
                emit_reg     <= 1'b0;
                dat_ones_reg <= 3'h0;
            end
            if (bit_stb) begin
                win_reg <= win_new;
                if (!rx_bit) begin
                    raw_ones_reg <= 3'h0;
                end else if (raw_ones_reg != `HDORX_ABORT_ONES) begin
                    raw_ones_reg <= raw_ones_reg + 3'h1;
                end
                if (data_ok) begin
                    if (stuffed || !out_bit) begin
                        dat_ones_reg <= 3'h0;
                    end else begin
                        dat_ones_reg <= dat_ones_reg + 3'h1;
                    end
                end
                if (take) begin
                    crc_reg  <= crc_step(crc_reg, out_bit);
                    asm_reg  <= asm_new;
                    bpos_reg <= bpos_reg + 3'h1;
                end
                if (byte_done) begin
                    h0_reg <= byte_ord;
                    h1_reg <= h0_reg;
                    h2_reg <= h1_reg;
                    if (hcnt_reg >= hold_lim) begin
                        emit_reg <= 1'b1;
                    end else begin
                        hcnt_reg <= hcnt_reg + 2'h1;
                    end
                end
                if (flag_hit) begin
                    vcnt_reg <= 4'h0;
                    st_reg   <= ST_PKT;
                    case (st_reg)
                        ST_PKT:  pend_reg <= PD_END;
                        default: pend_reg <= PD_CLR;
                    endcase
                end else if (raw_abt) begin
                    st_reg   <= ST_DISC;
                    pend_reg <= PD_ABT;
                end else if (vcnt_reg != `HDORX_BYTE_BITS) begin
                    vcnt_reg <= vcnt_reg + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // FIFO storage
    // ------------------------------------------------------------
    // Storage has no reset; pointers alone define the contents
    always @(posedge ref_clk_i) begin
        if (clk_en_i) begin
            if (do_wr) begin
                mem[wr_addr] <= wr_ent;
            end else if (do_mark) begin
                mem[prv_addr] <= mem[prv_addr] | 13'h0400;
            end
        end
    end

    // ------------------------------------------------------------
    // FIFO pointers and registers
    // ------------------------------------------------------------
    always @* begin
        rd_word = 32'h00000000;
        rd_err  = 1'b0;
        case (paddr_i)
            `HDORX_CTRL_OFS: begin
                rd_word[15:0] = ctrl_reg;
            end
            `HDORX_STAT_OFS: begin
                rd_word[`HDORX_STAT_EMPTY] = empty;
                rd_word[`HDORX_STAT_FULL]  = full;
                rd_word[`HDORX_STAT_AVAIL] = avail;
                rd_word[`HDORX_STAT_LVL_LSB+PW-1:`HDORX_STAT_LVL_LSB] = level;
            end
            `HDORX_STICKY_OFS: begin
                rd_word[1:0] = sticky_reg;
            end
            `HDORX_DATA_OFS: begin
                // Unwritten storage must not leak onto the bus on an empty read
                rd_word[12:0] = empty ? 13'h0000 : mem[rd_addr];
                rd_word[`HDORX_DATA_VALID] = ~empty;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_reg    <= `HDORX_CTRL_RST;
            sticky_reg  <= 2'b00;
            disc_reg    <= 1'b0;
            wr_gray_reg <= {PW{1'b0}};
            rd_gray_reg <= {PW{1'b0}};
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
            rd_ok_reg   <= 1'b0;
        end else if (clk_en_i) begin
            sticky_reg <= sticky_next;
            if (do_wr) begin
                wr_gray_reg <= b2g(wr_bin + {{(PW-1){1'b0}}, 1'b1});
            end
            if (ovf_set) begin
                disc_reg <= 1'b1;
            end else if (do_wr) begin
                disc_reg <= 1'b0;
            end
            if (pop) begin
                rd_gray_reg <= b2g(rd_bin + {{(PW-1){1'b0}}, 1'b1});
            end
            if (wr_ctrl) begin
                ctrl_reg <= pwdata_i[15:0];
            end
            // Answer is captured in the setup cycle, so the access needs no wait
            if (apb_setup) begin
                prdata_reg  <= pwrite_i ? 32'h00000000 : rd_word;
                pslverr_reg <= rd_err;
                rd_ok_reg   <= ~empty;
            end
        end
    end

endmodule
